// >>> logic/lap_defines.svh
/*
 holds the numbers of the laser power block.
 assumes an 8-bit register port and a 125 MHz clock.
*/
// Behaviour
// - comparator raise, lower or hold steps bias
// - 36-entry temperature table supplies set point
// - power-up zeroes swing and bias codes
// - swing loads after temperature, optional supply check
// - bias ramps by start step until above
// - binary search, then single-step tracking
// - trip alarms masked until search done
// - startup steps never exceed bias limit
// - restart after disable skips temperature wait once a temperature conversion is seen
// - disable pin shuts outputs, release restarts
// - software disable bit equals the pin
// - eight comparator slots, five for loop
// - power trip slot picks high or low
// - fixed sample interval, rate register selects
// - slot trip alarms held until sample clears, bias limit alarm follows its flag each cycle
// - bias limit flag, bias held at limit
// - loop ignored for settle samples after change
// - masked alarms shut outputs, raise fault
// - thresholds on feedback, bias and receive inputs
// - high-bias threshold from eight temperature levels
// - six-channel round robin, monitor right shifts
`ifndef LAP_DEFINES_SVH
`define LAP_DEFINES_SVH
// ==========================
// register offsets
`define LAP_OFS_TABLE_LAST 8'h23
`define LAP_OFS_HI_POWER 8'h60
`define LAP_OFS_LO_POWER 8'h61
`define LAP_OFS_LOW_SIGNAL 8'h62
`define LAP_OFS_BIAS_LIMIT 8'h63
`define LAP_OFS_ALARM_EN 8'h64
`define LAP_OFS_SWING_RD 8'h65
`define LAP_OFS_BIAS_RD 8'h66
`define LAP_OFS_CONTROL 8'h6e
`define LAP_OFS_STATUS 8'h6f
`define LAP_OFS_RATE 8'h88
`define LAP_OFS_SHIFT_A 8'h8d
`define LAP_OFS_SHIFT_B 8'h8e
`define LAP_OFS_START_STEP 8'hbb
`define LAP_OFS_HB_LVL0 8'hc8
`define LAP_OFS_HB_LVL7 8'hcf
`define LAP_OFS_HB_LEVELS 8'hd1
// ==========================
// control fields
`define LAP_CTL_SOFT_DIS 6
`define LAP_CTL_SUPPLY_EN 1
`define LAP_CTL_LOSS_EN 0
// ==========================
// reset values
`define LAP_RST_STEP 8'h08
`define LAP_RST_LIMIT 8'hff
`define LAP_RST_ZERO 8'h00
// ==========================
// timing
`define LAP_CLK_MHZ 125
`define LAP_SAMPLE_NS 1600
`define LAP_SAMPLE_CYC ((`LAP_SAMPLE_NS * `LAP_CLK_MHZ) / 1000)
`define LAP_SETTLE_SAMPLES 32
`endif

// >>> logic/lap_pkg.sv
/*
 holds the types of the laser power block.
 assumes lap_defines.svh for the numbers.
*/
package lap_pkg;
   // ==========================
   // startup and loop states
   typedef enum logic [2:0] {
      LAP_OFF,
      LAP_WAIT_TEMP,
      LAP_WAIT_SUPPLY,
      LAP_RAMP,
      LAP_SEARCH,
      LAP_TRACK
   } lap_state_t;
   // ==========================
   // trip alarms travel together
   typedef struct packed {
      logic biasLimit;
      logic lowSignal;
      logic highBias;
      logic lowPower;
      logic highPower;
   } lap_alarm_t;
endpackage

// >>> logic/lap_apc_ctrl.sv
/*
 holds the power loop, startup search, trip slots and alarm routing.
 assumes analog comparator outputs arrive asynchronously; converter and
 table inputs come from logic on the same clock.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "lap_defines.svh"
module lap_apc_ctrl
   import lap_pkg::*;
#(
   parameter int SAMPLE_CYC = `LAP_SAMPLE_CYC,
   parameter int SETTLE_SAMPLES = `LAP_SETTLE_SAMPLES
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic cmpAbove,
   input wire logic cmpBelow,
   input wire logic txDisablePin,
   input wire logic tempConvDone,
   input wire logic [5:0] tempIndex,
   input wire logic supplyConvDone,
   input wire logic supplyAboveLow,
   input wire logic [7:0] swingTableValue,
   input wire logic convAlarm,
   input wire logic adcValid,
   input wire logic [15:0] adcData,
   output logic [2:0] convChan,
   output logic [15:0] monResult,
   output logic monResultValid,
   output logic [1:0] cmpSource,
   output logic [7:0] cmpRef,
   output logic [7:0] biasDac,
   output logic [7:0] driveSwingDac,
   output logic txFaultOut,
   output logic txDisableOut,
   output logic signalLossOut
);
   // ==========================
   // helpers
   // add clipped at the limit
   function automatic logic [7:0] addClip(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] lim);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      addClip = (s > {1'b0, lim}) ? lim : s[7:0];
   endfunction

   // ==========================
   // registers
   logic [7:0] teTable_q [36]; // set point per 4 degree window
   logic [7:0] hbLevel_q [8]; // high-bias thresholds
   logic [7:0] hiPower_q, loPower_q, lowSignal_q, biasLimit_q;
   logic [7:0] alarmEn_q; // fault masks
   logic [7:0] control_q;
   logic [7:0] rate_q; // low nibble settle field, high nibble rate
   logic [7:0] shiftA_q, shiftB_q;
   logic [7:0] startStep_q;
   logic [7:0] hbLevels_q;
   logic [7:0] rdData_q;
   lap_alarm_t alarm_q;
   lap_state_t state_q;
   logic [7:0] bias_q, swing_q, adj_q;
   logic biasLimitFlag_q, faultQ, tempKnown_q, lastAbove_q;
   logic [15:0] sampleCnt_q;
   logic [2:0] slot_q;
   logic [11:0] settle_q;
   logic [2:0] chan_q;
   logic [15:0] mon_q;
   logic monValid_q;
   logic [1:0] src_q;
   logic [7:0] ref_q;
   logic aboveMeta_q, above_q, belowMeta_q, below_q, disMeta_q, dis_q;
   logic disPrev_q;

   // ==========================
   // synchronisers for pins and comparator
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aboveMeta_q <= 1'b0;
         above_q <= 1'b0;
         belowMeta_q <= 1'b0;
         below_q <= 1'b0;
         disMeta_q <= 1'b1;
         dis_q <= 1'b1;
      end
      else
      begin
         aboveMeta_q <= cmpAbove;
         above_q <= aboveMeta_q;
         belowMeta_q <= cmpBelow;
         below_q <= belowMeta_q;
         disMeta_q <= txDisablePin;
         dis_q <= disMeta_q;
      end
   end

   // ==========================
   // derived controls
   logic disable_w, sampleTick, loopSlot, loopValid, searchDone;
   logic [5:0] teIdx;
   logic [2:0] hbIdx;
   assign disable_w = dis_q | control_q[`LAP_CTL_SOFT_DIS];
   assign sampleTick = (sampleCnt_q == 16'h0000);
   assign loopSlot = (slot_q <= 3'h4);
   assign loopValid = sampleTick && loopSlot && (settle_q == 12'h000);
   assign searchDone = (state_q == LAP_TRACK);
   assign teIdx = (tempIndex > 6'd35) ? 6'd35 : tempIndex;
   // level follows temperature, capped
   assign hbIdx = (tempIndex[5:3] > hbLevels_q[2:0]) ? hbLevels_q[2:0] : tempIndex[5:3];

   // ==========================
   // register writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 36; i++) teTable_q[i] <= `LAP_RST_ZERO;
         for (int i = 0; i < 8; i++) hbLevel_q[i] <= `LAP_RST_LIMIT;
         hiPower_q <= `LAP_RST_LIMIT;
         loPower_q <= `LAP_RST_ZERO;
         lowSignal_q <= `LAP_RST_ZERO;
         biasLimit_q <= `LAP_RST_LIMIT;
         alarmEn_q <= `LAP_RST_ZERO;
         control_q <= `LAP_RST_ZERO;
         rate_q <= `LAP_RST_ZERO;
         shiftA_q <= `LAP_RST_ZERO;
         shiftB_q <= `LAP_RST_ZERO;
         startStep_q <= `LAP_RST_STEP;
         hbLevels_q <= `LAP_RST_ZERO;
      end
      else if (regWr)
      begin
         if (regAddr <= `LAP_OFS_TABLE_LAST)
            teTable_q[regAddr[5:0]] <= regWrData;
         else if (regAddr >= `LAP_OFS_HB_LVL0 && regAddr <= `LAP_OFS_HB_LVL7)
            hbLevel_q[regAddr[2:0]] <= regWrData;
         case (regAddr)
            `LAP_OFS_HI_POWER: hiPower_q <= regWrData;
            `LAP_OFS_LO_POWER: loPower_q <= regWrData;
            `LAP_OFS_LOW_SIGNAL: lowSignal_q <= regWrData;
            `LAP_OFS_BIAS_LIMIT: biasLimit_q <= regWrData;
            `LAP_OFS_ALARM_EN: alarmEn_q <= regWrData;
            `LAP_OFS_CONTROL: control_q <= regWrData;
            `LAP_OFS_RATE: rate_q <= regWrData;
            `LAP_OFS_SHIFT_A: shiftA_q <= regWrData;
            `LAP_OFS_SHIFT_B: shiftB_q <= regWrData;
            `LAP_OFS_START_STEP: startStep_q <= regWrData;
            `LAP_OFS_HB_LEVELS: hbLevels_q <= regWrData;
            default: ;
         endcase
      end
   end

   // ==========================
   // register reads, data one cycle later, unmapped read as zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdData_q <= 8'h00;
      else if (regRd)
      begin
         if (regAddr <= `LAP_OFS_TABLE_LAST)
            rdData_q <= teTable_q[regAddr[5:0]];
         else if (regAddr >= `LAP_OFS_HB_LVL0 && regAddr <= `LAP_OFS_HB_LVL7)
            rdData_q <= hbLevel_q[regAddr[2:0]];
         else
            case (regAddr)
               `LAP_OFS_HI_POWER: rdData_q <= hiPower_q;
               `LAP_OFS_LO_POWER: rdData_q <= loPower_q;
               `LAP_OFS_LOW_SIGNAL: rdData_q <= lowSignal_q;
               `LAP_OFS_BIAS_LIMIT: rdData_q <= biasLimit_q;
               `LAP_OFS_ALARM_EN: rdData_q <= alarmEn_q;
               `LAP_OFS_SWING_RD: rdData_q <= swing_q;
               `LAP_OFS_BIAS_RD: rdData_q <= bias_q;
               `LAP_OFS_CONTROL: rdData_q <= control_q;
               `LAP_OFS_STATUS: rdData_q <= {faultQ, searchDone, 1'b0, alarm_q};
               `LAP_OFS_RATE: rdData_q <= rate_q;
               `LAP_OFS_SHIFT_A: rdData_q <= shiftA_q;
               `LAP_OFS_SHIFT_B: rdData_q <= shiftB_q;
               `LAP_OFS_START_STEP: rdData_q <= startStep_q;
               `LAP_OFS_HB_LEVELS: rdData_q <= hbLevels_q;
               default: rdData_q <= 8'h00;
            endcase
      end
      else
         rdData_q <= 8'h00;
   end

   // ==========================
   // sample interval: base interval times rate option
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sampleCnt_q <= 16'h0000;
         slot_q <= 3'h0;
      end
      else if (sampleTick)
      begin
         // rate nibble stretches the interval
         sampleCnt_q <= 16'((SAMPLE_CYC * (int'(rate_q[7:4]) + 1)) - 1);
         slot_q <= slot_q + 3'h1;
      end
      else
         sampleCnt_q <= sampleCnt_q - 16'h0001;
   end

   // ==========================
   // comparator source and reference per slot
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_q <= 2'h0;
         ref_q <= 8'h00;
      end
      else
         case (slot_q)
            3'h5:
            begin
               src_q <= 2'h0; // feedback input
               ref_q <= lastAbove_q ? hiPower_q : loPower_q;
            end
            3'h6:
            begin
               src_q <= 2'h1; // bias monitor input
               ref_q <= hbLevel_q[hbIdx];
            end
            3'h7:
            begin
               src_q <= 2'h2; // receive power input
               ref_q <= lowSignal_q;
            end
            default:
            begin
               src_q <= 2'h0;
               ref_q <= teTable_q[teIdx];
            end
         endcase
   end

   // ==========================
   // trip alarms, refreshed by own slot; bias limit refreshed every cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm_q <= '0;
         lastAbove_q <= 1'b0;
      end
      else
      begin
         alarm_q.biasLimit <= biasLimitFlag_q;
         if (sampleTick)
            case (slot_q)
               3'h5:
               begin
                  if (lastAbove_q)
                     alarm_q.highPower <= above_q;
                  else
                     alarm_q.lowPower <= !above_q;
               end
               3'h6: alarm_q.highBias <= above_q;
               3'h7: alarm_q.lowSignal <= !above_q;
               default: lastAbove_q <= above_q;
            endcase
      end
   end

   // ==========================
   // settle window after a loop change
   logic biasChange;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         settle_q <= 12'h000;
      else if (biasChange)
         settle_q <= 12'(SETTLE_SAMPLES * (int'(rate_q[3:0]) + 1));
      else if (sampleTick && settle_q != 12'h000)
         settle_q <= settle_q - 12'h001;
   end

   // ==========================
   // startup sequence and loop
   logic [7:0] upBias, dnBias;
   assign upBias = addClip(bias_q, adj_q, biasLimit_q);
   assign dnBias = (bias_q > adj_q) ? bias_q - adj_q : 8'h00;
   assign biasChange = loopValid && (state_q == LAP_RAMP || state_q == LAP_SEARCH
      || state_q == LAP_TRACK) && (above_q != below_q);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= LAP_WAIT_TEMP;
         bias_q <= 8'h00;
         swing_q <= 8'h00;
         adj_q <= 8'h00;
         biasLimitFlag_q <= 1'b0;
      end
      else if (disable_w || faultQ)
      begin
         state_q <= LAP_OFF;
         bias_q <= 8'h00;
         swing_q <= 8'h00;
      end
      else
         case (state_q)
            LAP_OFF:
               // known temperature lets a restart skip the temperature wait
               state_q <= tempKnown_q ? LAP_WAIT_SUPPLY : LAP_WAIT_TEMP;
            LAP_WAIT_TEMP:
               if (tempConvDone)
                  state_q <= LAP_WAIT_SUPPLY;
            LAP_WAIT_SUPPLY:
               if (!control_q[`LAP_CTL_SUPPLY_EN] || (supplyConvDone && supplyAboveLow))
               begin
                  swing_q <= swingTableValue;
                  bias_q <= (startStep_q > biasLimit_q) ? biasLimit_q : startStep_q;
                  adj_q <= startStep_q;
                  state_q <= LAP_RAMP;
               end
            LAP_RAMP:
               if (loopValid)
               begin
                  if (above_q || bias_q == biasLimit_q
                     || {1'b0, bias_q} + {1'b0, adj_q} > {1'b0, biasLimit_q})
                  begin
                     adj_q <= adj_q >> 1;
                     state_q <= (adj_q <= 8'h01) ? LAP_TRACK : LAP_SEARCH;
                  end
                  else
                     bias_q <= bias_q + adj_q;
               end
            LAP_SEARCH:
               if (loopValid)
               begin
                  if (above_q)
                     bias_q <= dnBias;
                  else if ({1'b0, bias_q} + {1'b0, adj_q} <= {1'b0, biasLimit_q})
                     bias_q <= bias_q + adj_q;
                  adj_q <= adj_q >> 1;
                  if (adj_q <= 8'h01)
                     state_q <= LAP_TRACK;
               end
            LAP_TRACK:
               if (loopValid)
               begin
                  if (above_q && !below_q && bias_q != 8'h00)
                     bias_q <= bias_q - 8'h01;
                  else if (below_q && !above_q)
                     bias_q <= addClip(bias_q, 8'h01, biasLimit_q);
               end
            default: state_q <= LAP_OFF;
         endcase
      // limit flag refreshed from the code now in force
      if (rst_n)
         biasLimitFlag_q <= (bias_q >= biasLimit_q) && (state_q != LAP_OFF);
   end

   // ==========================
   // temperature known, and fault latch cleared by disable
   logic [4:0] tripEn;
   assign tripEn = alarmEn_q[4:0] & {5{searchDone}};
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tempKnown_q <= 1'b0;
         faultQ <= 1'b0;
         disPrev_q <= 1'b1;
      end
      else
      begin
         disPrev_q <= disable_w;
         if (tempConvDone)
            tempKnown_q <= 1'b1;
         // a new alarm wins over the clearing toggle
         if ((|(alarm_q & tripEn)) || (convAlarm && alarmEn_q[5]))
            faultQ <= 1'b1;
         else if (disable_w && !disPrev_q)
            faultQ <= 1'b0;
      end
   end

   // ==========================
   // converter round robin and monitor right shift
   logic [2:0] shAmt;
   always_comb
   begin
      case (chan_q)
         3'h2: shAmt = shiftA_q[2:0];
         3'h3: shAmt = shiftA_q[5:3];
         3'h4: shAmt = shiftB_q[2:0];
         3'h5: shAmt = shiftB_q[5:3];
         default: shAmt = 3'h0; // temperature and supply not shifted
      endcase
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_q <= 3'h0;
         mon_q <= 16'h0000;
         monValid_q <= 1'b0;
      end
      else
      begin
         monValid_q <= adcValid;
         if (adcValid)
         begin
            mon_q <= adcData >> shAmt;
            chan_q <= (chan_q == 3'h5) ? 3'h0 : chan_q + 3'h1;
         end
      end
   end

   // ==========================
   // registered outputs
   logic txFault_q, txDis_q, loss_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txFault_q <= 1'b0;
         txDis_q <= 1'b1;
         loss_q <= 1'b0;
      end
      else
      begin
         txFault_q <= faultQ;
         txDis_q <= faultQ || disable_w;
         loss_q <= alarm_q.lowSignal && control_q[`LAP_CTL_LOSS_EN];
      end
   end
   assign regRdData = rdData_q;
   assign convChan = chan_q;
   assign monResult = mon_q;
   assign monResultValid = monValid_q;
   assign cmpSource = src_q;
   assign cmpRef = ref_q;
   assign biasDac = bias_q;
   assign driveSwingDac = swing_q;
   assign txFaultOut = txFault_q;
   assign txDisableOut = txDis_q;
   assign signalLossOut = loss_q;
endmodule

// >>> verification/lap_apc_chk.sv
/*
 port assertions of the laser power block.
 assumes binding to lap_apc_ctrl, ports only.
*/
`timescale 1ns/1ps
`include "lap_defines.svh"
module lap_apc_chk #(
   parameter int SAMPLE_CYC = 4,
   parameter int SETTLE_SAMPLES = 2
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic tempConvDone,
   input wire logic txDisablePin,
   input wire logic [1:0] cmpSource,
   input wire logic [7:0] biasDac,
   input wire logic [7:0] driveSwingDac,
   input wire logic txFaultOut,
   input wire logic txDisableOut
);
   // ==========================
   // helper state
   logic tempSeen_q; // temperature seen
   logic [7:0] step_q; // mirror of the start step
   logic [7:0] limit_q; // mirror of the bias limit
   logic [1:0] src_q; // last sampled comparator source
   logic [7:0] since_q; // cycles since source moved, saturates
   // mirrors follow register writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tempSeen_q <= 1'b0;
         step_q <= `LAP_RST_STEP;
         limit_q <= `LAP_RST_LIMIT;
      end
      else
      begin
         if (tempConvDone) tempSeen_q <= 1'b1;
         if (regWr && regAddr == `LAP_OFS_START_STEP) step_q <= regWrData;
         if (regWr && regAddr == `LAP_OFS_BIAS_LIMIT) limit_q <= regWrData;
      end
   end
   // slot spacing counter; starts saturated so the first move is legal
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_q <= 2'h0;
         since_q <= 8'hff;
      end
      else
      begin
         src_q <= cmpSource;
         since_q <= (cmpSource != src_q) ? 8'h00 : (since_q == 8'hff ? since_q : since_q + 8'h01);
      end
   end
   // ==========================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_idle; !$past(regRd) |-> regRdData == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rst_zero; !$past(rst_n) |-> biasDac == 8'h00 && driveSwingDac == 8'h00; endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("dacs not zero");
   property p_swing_temp; driveSwingDac != 8'h00 |-> tempSeen_q; endproperty
   a_swing_temp: assert property (p_swing_temp) else $error("early swing");
   property p_first_bias;
      $past(biasDac) == 8'h00 && biasDac != 8'h00 |-> biasDac == ((step_q > limit_q) ? limit_q : step_q);
   endproperty
   a_first_bias: assert property (p_first_bias) else $error("bad first bias");
   property p_bias_limit; biasDac <= limit_q; endproperty
   a_bias_limit: assert property (p_bias_limit) else $error("bias above limit");
   property p_dis_dacs; txDisableOut && $past(txDisableOut) |-> biasDac == 8'h00 && driveSwingDac == 8'h00; endproperty
   a_dis_dacs: assert property (p_dis_dacs) else $error("dacs live");
   property p_pin_dis; txDisablePin [*4] |=> txDisableOut; endproperty
   a_pin_dis: assert property (p_pin_dis) else $error("pin ignored");
   property p_fault_dis; txFaultOut && $past(txFaultOut) |-> txDisableOut && biasDac == 8'h00; endproperty
   a_fault_dis: assert property (p_fault_dis) else $error("fault not shut");
   property p_slot_gap; cmpSource != src_q |-> since_q >= SAMPLE_CYC - 1; endproperty
   a_slot_gap: assert property (p_slot_gap) else $error("short slot");
   property p_slot_order; cmpSource != src_q |-> cmpSource == ((src_q == 2'h2) ? 2'h0 : src_q + 2'h1); endproperty
   a_slot_order: assert property (p_slot_order) else $error("bad slot order");
   // ==========================
   // covers
   c_fault: cover property ($rose(txFaultOut));
   c_at_limit: cover property (biasDac == limit_q && biasDac != 8'h00);
   c_restart: cover property ($fell(txDisableOut));
endmodule
bind lap_apc_ctrl lap_apc_chk #(.SAMPLE_CYC(SAMPLE_CYC), .SETTLE_SAMPLES(SETTLE_SAMPLES)) u_lap_apc_chk (
   .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .tempConvDone(tempConvDone), .txDisablePin(txDisablePin), .cmpSource(cmpSource),
   .biasDac(biasDac), .driveSwingDac(driveSwingDac), .txFaultOut(txFaultOut), .txDisableOut(txDisableOut));

// >>> verification/lap_afe_model.sv
/*
 far side model: laser, photodiode, receive input.
 assumes power and bias monitor follow the bias code.
*/
`timescale 1ns/1ps
module lap_afe_model #(
   parameter int LAG_NS = 2
)(
   input wire logic [7:0] biasDac,
   input wire logic [1:0] cmpSource,
   input wire logic [7:0] cmpRef,
   input wire logic [7:0] rxLevel,
   output logic cmpAbove,
   output logic cmpBelow
);
   logic [7:0] level; // voltage on the selected monitor input
   // feedback and bias monitor both track the bias code
   always_comb level = (cmpSource == 2'h2) ? rxLevel : biasDac;
   // equal gives neither flag (hold); lag mimics a slow comparator
   assign #(LAG_NS) cmpAbove = level > cmpRef;
   assign #(LAG_NS) cmpBelow = level < cmpRef;
endmodule

// >>> verification/lap_apc_ctrl_tb.sv
/*
 self-checking bench of the laser power block.
 assumes the model closes the loop; short sample counts.
*/
`timescale 1ns/1ps
`include "lap_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module lap_apc_ctrl_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic regWr = 1'b0, regRd = 1'b0, txDisablePin = 1'b1, tempConvDone = 1'b0, supplyConvDone = 1'b0;
   logic supplyAboveLow = 1'b1, convAlarm = 1'b0, adcValid = 1'b0; // supply and alarm held quiet
   logic cmpAbove, cmpBelow, monResultValid, txFaultOut, txDisableOut, signalLossOut;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, swingTableValue = 8'h5a, rxLevel = 8'h10;
   logic [7:0] regRdData, cmpRef, biasDac, driveSwingDac, v;
   logic [5:0] tempIndex = 6'h05; // fixed temperature window
   logic [15:0] adcData = 16'h0000, monResult;
   logic [2:0] convChan;
   logic [1:0] cmpSource;
   int n_mismatch = 0, compares = 0;
   // ==========================
   // block and far side
   lap_apc_ctrl #(.SAMPLE_CYC(4), .SETTLE_SAMPLES(2)) u_lap_apc_ctrl (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .cmpAbove(cmpAbove), .cmpBelow(cmpBelow), .txDisablePin(txDisablePin), .tempConvDone(tempConvDone),
      .tempIndex(tempIndex), .supplyConvDone(supplyConvDone), .supplyAboveLow(supplyAboveLow),
      .swingTableValue(swingTableValue), .convAlarm(convAlarm), .adcValid(adcValid), .adcData(adcData),
      .convChan(convChan), .monResult(monResult), .monResultValid(monResultValid), .cmpSource(cmpSource),
      .cmpRef(cmpRef), .biasDac(biasDac), .driveSwingDac(driveSwingDac), .txFaultOut(txFaultOut),
      .txDisableOut(txDisableOut), .signalLossOut(signalLossOut));
   lap_afe_model u_lap_afe_model (.biasDac(biasDac), .cmpSource(cmpSource), .cmpRef(cmpRef),
      .rxLevel(rxLevel), .cmpAbove(cmpAbove), .cmpBelow(cmpBelow));
   // ==========================
   // clock and access tasks
   initial
   begin
      forever #4 clk = ~clk;
   end
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk) regWr <= 1'b0;
   endtask
   // data stands only the cycle after
   task automatic rd(input logic [7:0] a);
      @(posedge clk) regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk) regRd <= 1'b0;
      #1 v = regRdData;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic adc(input logic [15:0] d);
      @(posedge clk) adcValid <= 1'b1;
      adcData <= d;
      @(posedge clk) adcValid <= 1'b0;
      #1;
   endtask
   // bounded status poll
   task automatic wait_status(input logic [7:0] m);
      for (int i = 0; i < 600; i++)
      begin
         rd(`LAP_OFS_STATUS);
         if ((v & m) === m) break;
      end
   endtask
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================
   // watchdog, far past a few thousand cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      close_out;
   end
   // ==========================
   // scenarios
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
      `CHK(biasDac, 8'h00)
      `CHK(driveSwingDac, 8'h00)
      rd(`LAP_OFS_START_STEP);
      `CHK(v, `LAP_RST_STEP)
      rd(`LAP_OFS_BIAS_LIMIT);
      `CHK(v, `LAP_RST_LIMIT)
      rd(8'h40);
      `CHK(v, 8'h00)
      wr(8'h05, 8'h40); // set point of the present window
      wr(`LAP_OFS_START_STEP, 8'h10);
      wr(`LAP_OFS_SHIFT_A, 8'h03);
      repeat (3) adc(16'h0800); // third result is the first monitor
      `CHK(monResult, 16'h0100)
      `CHK(monResultValid, 1'b1)
      `CHK(convChan, 3'h3)
      wr(`LAP_OFS_CONTROL, 8'h02); // supply check on
      @(posedge clk) txDisablePin <= 1'b0;
      tick(40);
      `CHK(driveSwingDac, 8'h00)
      @(posedge clk) tempConvDone <= 1'b1;
      @(posedge clk) tempConvDone <= 1'b0;
      tick(40);
      `CHK(driveSwingDac, 8'h00)
      @(posedge clk) supplyConvDone <= 1'b1;
      @(posedge clk) supplyConvDone <= 1'b0;
      tick(6);
      `CHK(driveSwingDac, 8'h5a)
      wait_status(8'h40);
      `CHK(v[6], 1'b1)
      tick(300);
      `CHK(biasDac, 8'h40)
      // low threshold while loop not above
      wr(`LAP_OFS_LO_POWER, 8'h50);
      tick(100);
      rd(`LAP_OFS_STATUS);
      `CHK(v[1:0], 2'h2)
      wr(`LAP_OFS_LO_POWER, 8'h00);
      wr(`LAP_OFS_HI_POWER, 8'h30);
      wr(8'h05, 8'h30);
      tick(500);
      `CHK(biasDac, 8'h30)
      rd(`LAP_OFS_STATUS);
      `CHK(v[1:0], 2'h1)
      wr(`LAP_OFS_HI_POWER, 8'hff);
      wr(8'h05, 8'h40);
      wr(`LAP_OFS_LOW_SIGNAL, 8'h20);
      wr(`LAP_OFS_CONTROL, 8'h03);
      tick(100);
      `CHK(signalLossOut, 1'b1)
      @(posedge clk) rxLevel <= 8'h30;
      tick(100);
      `CHK(signalLossOut, 1'b0)
      wr(`LAP_OFS_CONTROL, 8'h40);
      tick(3);
      `CHK(txDisableOut, 1'b1)
      `CHK(biasDac, 8'h00)
      wr(`LAP_OFS_CONTROL, 8'h00);
      tick(8);
      `CHK(driveSwingDac, 8'h5a)
      // limit under set point stops climb
      @(posedge clk) txDisablePin <= 1'b1;
      tick(4);
      `CHK(txDisableOut, 1'b1)
      wr(`LAP_OFS_BIAS_LIMIT, 8'h38);
      @(posedge clk) txDisablePin <= 1'b0;
      tick(300);
      wait_status(8'h40);
      tick(200);
      `CHK(biasDac, 8'h38)
      rd(`LAP_OFS_STATUS);
      `CHK(v[4], 1'b1)
      wr(`LAP_OFS_ALARM_EN, 8'h10);
      tick(10);
      `CHK(txFaultOut, 1'b1)
      `CHK(biasDac, 8'h00)
      rd(`LAP_OFS_STATUS);
      `CHK(v[7], 1'b1)
      @(posedge clk) txDisablePin <= 1'b1;
      tick(4);
      @(posedge clk) txDisablePin <= 1'b0;
      tick(10);
      `CHK(txFaultOut, 1'b0)
      `CHK(driveSwingDac, 8'h5a)
      close_out;
   end
endmodule
